// [src/vhs_pkg.sv]
// Overview of operation
// - first capability byte reads 03h, writes to it are ignored
// - product-data link byte always reads ECh, pointing at hot-swap structure
// - 9-bit offset field, software uses offsets 000h to 17Fh only
// - rom address is programmed offset plus fixed base 080h
// - address register bits 14:9 read as zero
// - flag written zero reads four rom bytes, flag goes to one when done
// - flag written one writes four rom bytes, flag goes to zero when done
// - data byte 0 is the start offset, bytes 1 to 3 follow upward
// - hot-swap capability byte reads 06h
// - hot-swap link byte reads zero, last in the chain
// - mask clear lets card-event assert, mask set blocks it, resets zero
// - led force-on bit drives led pin high, resets zero
// - force-on zero and removal clear leaves led pin undriven
// - force-on zero and removal set keeps led pin driven low
// - removal-pending sets when led pin high and primary reset deasserted
// - writing one clears removal-pending and releases the led pin
// - insertion-pending sets on led low, preload done, lockout clear
// - writing one clears insertion-pending; both pending bits reset zero
// - either pending bit holds card-event asserted while the mask is clear
// - hot-swap control bits 0, 2 and 5:4 read as zero
package vhs_pkg;

  // ************************************************************
  // register map, byte addresses
  // ************************************************************
  localparam logic [7:0] PD_CAP_ID_OFS   = 8'hE4;
  localparam logic [7:0] PD_NEXT_OFS     = 8'hE5;
  localparam logic [7:0] PD_ADDRESS_OFS  = 8'hE6;
  localparam logic [7:0] PD_WORD_OFS     = 8'hE8;
  localparam logic [7:0] HS_CAP_ID_OFS   = 8'hEC;
  localparam logic [7:0] HS_NEXT_OFS     = 8'hED;
  localparam logic [7:0] HS_CONTROL_OFS  = 8'hEE;

  // ************************************************************
  // fixed values
  // ************************************************************
  localparam logic [7:0] PD_CAP_ID_VAL   = 8'h03;
  localparam logic [7:0] PD_NEXT_VAL     = 8'hEC;
  localparam logic [7:0] HS_CAP_ID_VAL   = 8'h06;
  localparam logic [7:0] HS_NEXT_VAL     = 8'h00;
  localparam logic [9:0] ROM_PD_BASE     = 10'h080;

  // ************************************************************
  // field positions
  // ************************************************************
  localparam int OFFSET_MSB   = 8;
  localparam int FLAG_BIT     = 15;
  localparam int MASK_BIT     = 1;
  localparam int LED_BIT      = 3;
  localparam int REM_BIT      = 6;
  localparam int INS_BIT      = 7;

  // ************************************************************
  // reset values and counts
  // ************************************************************
  localparam logic [8:0]  OFFSET_RST   = 9'h000;
  localparam logic        FLAG_RST     = 1'b0;
  localparam logic [31:0] WORD_RST     = 32'h0000_0000;
  localparam logic [1:0]  LAST_BYTE    = 2'h3;

  // ************************************************************
  // rom byte request carrier
  // ************************************************************
  typedef struct packed {
    logic       we;
    logic [9:0] addr;
    logic [7:0] wdata;
  } vhs_rom_req_t;

  typedef enum logic [1:0] {
    VHS_IDLE,
    VHS_REQ,
    VHS_GAP
  } vhs_state_t;

endpackage

// [src/vhs_regs.sv]
`timescale 1ns/1ps
module vhs_regs
(
  input  wire logic                 mclk,
  input  wire logic                 resetn,
  input  wire logic [7:0]           reg_addr,
  input  wire logic [31:0]          reg_wdata,
  input  wire logic                 reg_wr,
  input  wire logic                 reg_rd,
  output logic [31:0]               reg_rdata,
  output logic                      rom_req_valid,
  output vhs_pkg::vhs_rom_req_t     rom_req,
  input  wire logic                 rom_ack,
  input  wire logic [7:0]           rom_rdata,
  output logic                      rom_busy,
  input  wire logic                 led_in,
  output logic                      led_out,
  output logic                      led_oe,
  output logic                      card_event_n,
  input  wire logic                 prim_rst_n,
  input  wire logic                 preload_done,
  input  wire logic                 host_lockout
);
  import vhs_pkg::*;

  // ************************************************************
  // state
  // ************************************************************
  logic [8:0]   offset_reg;
  logic         flag_reg;
  logic [31:0]  word_reg;
  logic         mask_reg;
  logic         led_force_reg;
  logic         removal_reg;
  logic         insertion_reg;
  vhs_state_t   state_reg;
  logic [1:0]   byte_reg;
  logic         op_we_reg;

  logic         wr_addr;
  logic         wr_word;
  logic         wr_ctrl;
  logic         start;
  logic         removal_next;
  logic         insertion_next;

  assign wr_addr = reg_wr && (reg_addr == PD_ADDRESS_OFS);
  assign wr_word = reg_wr && (reg_addr == PD_WORD_OFS);
  assign wr_ctrl = reg_wr && (reg_addr == HS_CONTROL_OFS);
  // address and word writes that arrive while a rom access runs are dropped so the
  // access in flight keeps a stable offset and data word
  assign start   = wr_addr && (state_reg == VHS_IDLE);

  function automatic logic [7:0] word_byte(input logic [31:0] w, input logic [1:0] i);
    word_byte = w[{i, 3'b000} +: 8];
  endfunction

  // ************************************************************
  // product-data address and flag
  // ************************************************************
  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      offset_reg <= OFFSET_RST;
      flag_reg   <= FLAG_RST;
      op_we_reg  <= 1'b0;
    end
    else if (start)
    begin
      offset_reg <= reg_wdata[OFFSET_MSB:0];
      flag_reg   <= reg_wdata[FLAG_BIT];
      op_we_reg  <= reg_wdata[FLAG_BIT];
    end
    else if (state_reg == VHS_GAP && byte_reg == LAST_BYTE)
    begin
      flag_reg <= ~op_we_reg;
    end
  end

  // ************************************************************
  // rom byte sequencer
  // ************************************************************
  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      state_reg <= VHS_IDLE;
      byte_reg  <= 2'h0;
    end
    else
    begin
      unique case (state_reg)
        VHS_IDLE:
        begin
          if (start)
          begin
            state_reg <= VHS_REQ;
            byte_reg  <= 2'h0;
          end
        end
        VHS_REQ:
        begin
          if (rom_ack)
          begin
            state_reg <= VHS_GAP;
          end
        end
        VHS_GAP:
        begin
          if (byte_reg == LAST_BYTE)
          begin
            state_reg <= VHS_IDLE;
          end
          else
          begin
            state_reg <= VHS_REQ;
            byte_reg  <= byte_reg + 2'h1;
          end
        end
      endcase
    end
  end

  // one idle cycle between bytes lets the rom drop its ack first
  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      rom_req_valid <= 1'b0;
      rom_req       <= '0;
      rom_busy      <= 1'b0;
    end
    else
    begin
      rom_busy      <= start || (state_reg == VHS_REQ) ||
                       (state_reg == VHS_GAP && byte_reg != LAST_BYTE);
      rom_req_valid <= (state_reg == VHS_IDLE && start) ||
                       (state_reg == VHS_GAP && byte_reg != LAST_BYTE) ||
                       (state_reg == VHS_REQ && !rom_ack);
      if (state_reg == VHS_IDLE && start)
      begin
        rom_req.we    <= reg_wdata[FLAG_BIT];
        rom_req.addr  <= ROM_PD_BASE + {1'b0, reg_wdata[OFFSET_MSB:0]};
        rom_req.wdata <= word_byte(word_reg, 2'h0);
      end
      else if (state_reg == VHS_GAP && byte_reg != LAST_BYTE)
      begin
        rom_req.addr  <= rom_req.addr + 10'h001;
        rom_req.wdata <= word_byte(word_reg, byte_reg + 2'h1);
      end
    end
  end

  // ************************************************************
  // product-data word
  // ************************************************************
  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      word_reg <= WORD_RST;
    end
    else if (wr_word && state_reg == VHS_IDLE)
    begin
      word_reg <= reg_wdata;
    end
    else if (state_reg == VHS_REQ && rom_ack && !op_we_reg)
    begin
      word_reg[{byte_reg, 3'b000} +: 8] <= rom_rdata;
    end
  end

  // ************************************************************
  // hot-swap control
  // ************************************************************
  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      mask_reg      <= 1'b0;
      led_force_reg <= 1'b0;
    end
    else if (wr_ctrl)
    begin
      mask_reg      <= reg_wdata[MASK_BIT];
      led_force_reg <= reg_wdata[LED_BIT];
    end
  end

  // a set in the same cycle as a write-one clear wins
  always_comb
  begin
    removal_next   = removal_reg;
    insertion_next = insertion_reg;
    if (wr_ctrl && reg_wdata[REM_BIT])
    begin
      removal_next = 1'b0;
    end
    if (wr_ctrl && reg_wdata[INS_BIT])
    begin
      insertion_next = 1'b0;
    end
    if (led_in && prim_rst_n)
    begin
      removal_next = 1'b1;
    end
    if (!led_in && preload_done && !host_lockout)
    begin
      insertion_next = 1'b1;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      removal_reg   <= 1'b0;
      insertion_reg <= 1'b0;
    end
    else
    begin
      removal_reg   <= removal_next;
      insertion_reg <= insertion_next;
    end
  end

  // ************************************************************
  // pins
  // ************************************************************
  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      led_out      <= 1'b0;
      led_oe       <= 1'b0;
      card_event_n <= 1'b1;
    end
    else
    begin
      led_out      <= led_force_reg;
      led_oe       <= led_force_reg || removal_next;
      card_event_n <= !((removal_next || insertion_next) && !mask_reg);
    end
  end

  // ************************************************************
  // read path
  // ************************************************************
  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      reg_rdata <= 32'h0000_0000;
    end
    else if (reg_rd)
    begin
      unique case (reg_addr)
        PD_CAP_ID_OFS:  reg_rdata <= {24'h000000, PD_CAP_ID_VAL};
        PD_NEXT_OFS:    reg_rdata <= {24'h000000, PD_NEXT_VAL};
        PD_ADDRESS_OFS: reg_rdata <= {16'h0000, flag_reg, 6'h00, offset_reg};
        PD_WORD_OFS:    reg_rdata <= word_reg;
        HS_CAP_ID_OFS:  reg_rdata <= {24'h000000, HS_CAP_ID_VAL};
        HS_NEXT_OFS:    reg_rdata <= {24'h000000, HS_NEXT_VAL};
        HS_CONTROL_OFS: reg_rdata <= {24'h000000, insertion_reg, removal_reg, 2'h0,
                                      led_force_reg, 1'b0, mask_reg, 1'b0};
        default:        reg_rdata <= 32'h0000_0000;
      endcase
    end
    else
    begin
      reg_rdata <= 32'h0000_0000;
    end
  end

endmodule

// [sim/vhs_rom_model.sv]
`timescale 1ns/1ps
module vhs_rom_model
(
  input  wire logic                  mclk,
  input  wire logic                  rom_req_valid,
  input  wire vhs_pkg::vhs_rom_req_t rom_req,
  input  wire logic [1:0]            dly,
  output logic                       rom_ack,
  output logic [7:0]                 rom_rdata
);
  import vhs_pkg::*;
  logic [7:0] mem [1024];
  logic [1:0] cnt;
  initial
  begin
    rom_ack = 1'b0;
    rom_rdata = 8'h00;
    cnt = 2'h0;
    for (int i = 0; i < 1024; i++)
      mem[i] = i[7:0] ^ 8'h5A;
  end
  // data toggles outside the ack cycle so a late sample is caught
  always @(posedge mclk)
  begin
    rom_ack <= 1'b0;
    rom_rdata <= ~rom_rdata;
    cnt <= 2'h0;
    if (rom_req_valid && !rom_ack && cnt < dly)
      cnt <= cnt + 2'h1;
    else if (rom_req_valid && !rom_ack)
    begin
      rom_ack <= 1'b1;
      if (rom_req.we)
        mem[rom_req.addr] <= rom_req.wdata;
      else
        rom_rdata <= mem[rom_req.addr];
    end
  end
endmodule

// [sim/vhs_regs_sva.sv]
`timescale 1ns/1ps
module vhs_regs_sva
(
  input wire logic                  mclk,
  input wire logic                  resetn,
  input wire logic [7:0]            reg_addr,
  input wire logic [31:0]           reg_wdata,
  input wire logic                  reg_wr,
  input wire logic                  reg_rd,
  input wire logic [31:0]           reg_rdata,
  input wire logic                  rom_req_valid,
  input wire vhs_pkg::vhs_rom_req_t rom_req,
  input wire logic                  rom_ack,
  input wire logic                  rom_busy,
  input wire logic                  led_in,
  input wire logic                  led_oe,
  input wire logic                  card_event_n,
  input wire logic                  prim_rst_n
);
  logic hw;
  assign hw = reg_wr && reg_addr == 8'hEE;
  default clocking @(posedge mclk);
  endclocking
  default disable iff (!resetn);
  property p_id; reg_rd && reg_addr == 8'hE4 |=> reg_rdata == 32'h03; endproperty
  a_id: assert property (p_id) else $error("bad id");
  property p_lnk; reg_rd && reg_addr == 8'hE5 |=> reg_rdata == 32'hEC; endproperty
  a_lnk: assert property (p_lnk) else $error("bad link");
  property p_hid; reg_rd && reg_addr == 8'hEC |=> reg_rdata == 32'h06; endproperty
  a_hid: assert property (p_hid) else $error("bad hs id");
  property p_hrs; reg_rd && reg_addr == 8'hEE |=> (reg_rdata & 32'h35) == 32'h0; endproperty
  a_hrs: assert property (p_hrs) else $error("bad spare bits");
  property p_go;
    reg_wr && reg_addr == 8'hE6 && !rom_busy && !rom_req_valid |=> rom_req_valid
      && rom_req.addr == 10'h080 + $past(reg_wdata[8:0]) && rom_req.we == $past(reg_wdata[15]);
  endproperty
  a_go: assert property (p_go) else $error("bad start");
  property p_gap; rom_req_valid && rom_ack |=> !rom_req_valid; endproperty
  a_gap: assert property (p_gap) else $error("no gap");
  // a byte request outside a running access would reach the rom unannounced
  property p_busy; rom_req_valid |-> rom_busy; endproperty
  a_busy: assert property (p_busy) else $error("request while idle");
  property p_rem; led_in && prim_rst_n |-> ##[1:2] led_oe; endproperty
  a_rem: assert property (p_rem) else $error("pin not held");
  // a pending bit only goes away through a control write, so neither may the event
  property p_evt; $rose(card_event_n) |-> $past(hw) || $past(hw, 2) || $past(hw, 3); endproperty
  a_evt: assert property (p_evt) else $error("event dropped");
  c_op: cover property (rom_req_valid && rom_ack && rom_req.we);
  c_ev: cover property (!card_event_n);
  c_led: cover property (led_oe);
endmodule
bind vhs_regs vhs_regs_sva chk_i
(
  .mclk          (mclk),
  .resetn        (resetn),
  .reg_addr      (reg_addr),
  .reg_wdata     (reg_wdata),
  .reg_wr        (reg_wr),
  .reg_rd        (reg_rd),
  .reg_rdata     (reg_rdata),
  .rom_req_valid (rom_req_valid),
  .rom_req       (rom_req),
  .rom_ack       (rom_ack),
  .rom_busy      (rom_busy),
  .led_in        (led_in),
  .led_oe        (led_oe),
  .card_event_n  (card_event_n),
  .prim_rst_n    (prim_rst_n)
);

// [sim/vpd_hotswap_capability_regs_tb_top.sv]
`timescale 1ns/1ps
module vpd_hotswap_capability_regs_tb_top;
  import vhs_pkg::*;
  logic         mclk, resetn, reg_wr, reg_rd, rom_req_valid, rom_ack, rom_busy;
  logic         led_in, led_out, led_oe, card_event_n, prim_rst_n, preload_done;
  logic         host_lockout, handle;
  logic [7:0]   reg_addr, rom_rdata;
  logic [31:0]  reg_wdata, reg_rdata, rd_v, wd;
  logic [1:0]   dly;
  logic [8:0]   off;
  vhs_rom_req_t rom_req;
  logic [7:0]   mem [1024];
  logic [7:0]   ra [8] = '{8'hE4, 8'hE5, 8'hEC, 8'hED, 8'hE6, 8'hE8, 8'hEE, 8'hF0};
  logic [31:0]  rx [8] = '{32'h03, 32'hEC, 32'h06, 32'h00, 32'h0, 32'h0, 32'h0, 32'h0};
  int           fails, compares, n;
  vhs_regs DUT
  (
    .mclk          (mclk),
    .resetn        (resetn),
    .reg_addr      (reg_addr),
    .reg_wdata     (reg_wdata),
    .reg_wr        (reg_wr),
    .reg_rd        (reg_rd),
    .reg_rdata     (reg_rdata),
    .rom_req_valid (rom_req_valid),
    .rom_req       (rom_req),
    .rom_ack       (rom_ack),
    .rom_rdata     (rom_rdata),
    .rom_busy      (rom_busy),
    .led_in        (led_in),
    .led_out       (led_out),
    .led_oe        (led_oe),
    .card_event_n  (card_event_n),
    .prim_rst_n    (prim_rst_n),
    .preload_done  (preload_done),
    .host_lockout  (host_lockout)
  );
  vhs_rom_model rom_i
  (
    .mclk          (mclk),
    .rom_req_valid (rom_req_valid),
    .rom_req       (rom_req),
    .dly           (dly),
    .rom_ack       (rom_ack),
    .rom_rdata     (rom_rdata)
  );
  // handle switch sets the level wherever the device lets go of the pin
  assign led_in = led_oe ? led_out : handle;
  initial
  begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e)
    begin
      fails++;
      $display("BAD %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(negedge mclk);
    rd_v = reg_rdata;
  endtask
  task automatic final_report;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // registers stay untouched until the flag flips
  task automatic rom_op(input logic f, input logic [8:0] o);
    wr(8'hE6, {16'h0, f, 6'h0, o});
    rd_v = {16'h0, f, 15'h0};
    for (n = 0; n < 300 && rd_v[15] === f; n++)
      rd(8'hE6);
    if (n == 300)
    begin
      fails++;
      final_report;
    end
    chk(rd_v, {16'h0, ~f, 6'h0, o});
    chk({31'h0, rom_busy}, 32'h0);
  endtask
  task automatic hs(input logic [31:0] e, input logic [2:0] p);
    repeat (3) @(posedge mclk);
    rd(8'hEE);
    chk(rd_v, e);
    chk({29'h0, led_oe, led_oe & led_out, card_event_n}, {29'h0, p});
  endtask
  initial
  begin
    resetn = 1'b0;
    {reg_wr, reg_rd, reg_addr, reg_wdata, dly, handle} = '0;
    {prim_rst_n, preload_done, host_lockout} = 3'b111;
    {fails, compares} = '0;
    for (int i = 0; i < 1024; i++)
      mem[i] = i[7:0] ^ 8'h5A;
    void'($urandom(32'h2D377613));
    repeat (6) @(posedge mclk);
    resetn <= 1'b1;
    for (int i = 0; i < 12; i++)
    begin
      if (i >= 8)
        wr(ra[i - 8], 32'hFFFFFFFF);
      rd(ra[i % 8]);
      chk(rd_v, rx[i % 8]);
    end
    $display("id test done");
    for (int k = 0; k < 4; k++)
    begin
      @(posedge mclk);
      dly <= 2'($urandom);
      off = (k == 0) ? 9'h17E : 9'($urandom % 383);
      wd = $urandom;
      wr(8'hE8, wd);
      for (int j = 0; j < 4; j++)
        mem[ROM_PD_BASE + off + j] = wd[8 * j +: 8];
      rom_op(1'b1, off);
      rom_op(1'b0, off + 9'h1);
      for (int j = 0; j < 4; j++)
        wd[8 * j +: 8] = mem[ROM_PD_BASE + off + 1 + j];
      rd(8'hE8);
      chk(rd_v, wd);
    end
    $display("rom test done");
    @(posedge mclk);
    {preload_done, host_lockout} <= 2'b00;
    wr(8'hEE, 32'h0);
    hs(32'h0, 3'b001);
    @(posedge mclk);
    preload_done <= 1'b1;
    hs(32'h80, 3'b000);
    wr(8'hEE, 32'h2);
    hs(32'h82, 3'b001);
    @(posedge mclk);
    host_lockout <= 1'b1;
    wr(8'hEE, 32'h82);
    hs(32'h02, 3'b001);
    @(posedge mclk);
    {prim_rst_n, handle} <= 2'b01;
    wr(8'hEE, 32'h0);
    hs(32'h0, 3'b001);
    @(posedge mclk);
    prim_rst_n <= 1'b1;
    hs(32'h40, 3'b100);
    @(posedge mclk);
    handle <= 1'b0;
    wr(8'hEE, 32'h40);
    hs(32'h0, 3'b001);
    wr(8'hEE, 32'h8);
    hs(32'h48, 3'b110);
    wr(8'hEE, 32'h0);
    hs(32'h40, 3'b100);
    wr(8'hEE, 32'h40);
    hs(32'h0, 3'b001);
    $display("hotswap test done");
    final_report;
  end
endmodule
